// File: verilog/ccc_ctrl.sv
// control and status pin logic of the clock synthesizer, with axi4-lite registers
// Notes on behaviour
// RL1 - A reset pin held low for longer than 15 us causes a full device reset.
// RL2 - During reset all logic and registers return to defaults and clock outputs stay off; a pin reset here spares the AXI state and step synchronisers.
// RL3 - While power-on reset runs, the device pulls its reset pin low open-drain.
// RL4 - Outside logic drives the shared reset line open-drain only.
// RL5 - The interrupt output goes low whenever a device status change has occurred; here only for changes whose irq_mask bit is set.
// RL6 - The output enable pin gates only masked outputs, and the mask covers all after reset.
// RL7 - Each loss-of-lock output is low while its loop or the reference is unlocked.
// RL8 - A decrement assertion lowers the selected loop's frequency by one configured step.
// RL9 - An increment assertion raises the selected loop's frequency by one configured step.
// RL10 - A low strap at reset release selects bootloader mode; normally it is held high.
// RL11 - Above 100 kHz the device stretches the serial clock low to insert wait states.
// RL12 - Two address select pins form part of the serial target address.
// RL13 - Unused enable, increment and decrement pins are held low by the outside.
// RL14 - Step pins are synchronised and give exactly one step per rising edge.
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
module ccc_ctrl #(
   parameter int N_OUT = 7,
   parameter int STEP_W = 16,
   parameter logic [4:0] ADDR_BASE = 5'h1a
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // reset pin, open drain
   input wire logic device_reset_n_in,
   output logic device_reset_n_out,
   output logic device_reset_n_oe_n,
   input wire logic por_active,
   // control pins
   input wire logic output_enable_n,
   input wire logic freq_step_up,
   input wire logic freq_step_down,
   input wire logic boot_loader_strap_n,
   input wire logic bus_addr_sel_hi,
   input wire logic bus_addr_sel_lo,
   // loop lock state, bit order a, c, d, reference
   input wire logic [3:0] loop_locked,
   // serial clock stretch
   input wire logic serial_fast,
   input wire logic serial_wait_req,
   output logic scl_out,
   output logic scl_oe_n,
   // status pins
   output logic irq_n,
   output logic loop_a_unlocked_n,
   output logic loop_c_unlocked_n,
   output logic loop_d_unlocked_n,
   output logic reference_unlocked_n,
   // to the synthesis core
   output logic [N_OUT-1:0] clk_out_en,
   output logic step_up,
   output logic step_down,
   output logic [1:0] step_loop_sel,
   output logic [STEP_W-1:0] step_size,
   output logic boot_mode,
   output logic [6:0] bus_target_addr,
   output logic device_in_reset
);
   logic pin_reset;
   logic soft_rst_n;
   logic up_rise;
   logic dn_rise;
   logic [1:0] ctrl;
   logic [1:0] next_ctrl;
   logic [STEP_W-1:0] step;
   logic [STEP_W-1:0] next_step;
   logic [N_OUT-1:0] oe_mask;
   logic [N_OUT-1:0] next_oe_mask;
   logic [4:0] status;
   logic [4:0] next_status;
   logic [4:0] irq_mask;
   logic [4:0] next_irq_mask;
   logic [3:0] lock;
   logic [3:0] next_lock;
   logic was_rst;
   logic next_boot;
   logic [6:0] next_addr;
   logic [N_OUT-1:0] next_clk_en;
   logic next_up;
   logic next_dn;
   // axi state
   logic aw_held;
   logic next_aw_held;
   logic [7:0] aw_addr;
   logic [7:0] next_aw_addr;
   logic w_held;
   logic next_w_held;
   logic [31:0] w_data;
   logic [31:0] next_w_data;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic wr_fire;
   logic rd_fire;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == ccc_pkg::ADDR_CTRL) || (a == ccc_pkg::ADDR_STEP) ||
         (a == ccc_pkg::ADDR_OE_MASK) || (a == ccc_pkg::ADDR_STATUS) ||
         (a == ccc_pkg::ADDR_IRQ_MASK) || (a == ccc_pkg::ADDR_STATE);
   endfunction : mapped

   ccc_reset_filter u_rst (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin_n(device_reset_n_in),
      .pin_reset(pin_reset)
   );

   ccc_sync_edge u_up (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin(freq_step_up),
      .level(),
      .rise(up_rise)
   );

   ccc_sync_edge u_dn (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin(freq_step_down),
      .level(),
      .rise(dn_rise)
   );

   // RL1 pin reset applied
   assign soft_rst_n = rst_n & ~pin_reset;
   assign device_in_reset = ~soft_rst_n;

   // RL3 pull low during por
   assign device_reset_n_out = 1'b0;
   assign device_reset_n_oe_n = ~por_active;

   // RL11 stretch only when fast
   assign scl_out = 1'b0;
   assign scl_oe_n = ~(serial_fast & serial_wait_req);

   // RL5 low while any status bit whose irq_mask bit is set is set
   assign irq_n = ~|(status & irq_mask);

   // RL7 lock levels out
   assign loop_a_unlocked_n = lock[0];
   assign loop_c_unlocked_n = lock[1];
   assign loop_d_unlocked_n = lock[2];
   assign reference_unlocked_n = lock[3];

   assign step_loop_sel = ctrl;
   assign step_size = step;

   // axi handshakes: one write and one read held at a time
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   // built from the handshakes, not next_aw_held, to keep the next-state logic loop free
   assign wr_fire = (aw_held | (s_axi_awvalid & s_axi_awready)) &
      (w_held | (s_axi_wvalid & s_axi_wready)) & ~s_axi_bvalid;
   assign rd_fire = s_axi_arvalid & s_axi_arready;

   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_bvalid = s_axi_bvalid & ~s_axi_bready;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid & ~s_axi_rready;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = mapped(next_aw_addr) ? ccc_pkg::RESP_OKAY : ccc_pkg::RESP_SLVERR;
      end
      if (rd_fire) begin
         next_rvalid = 1'b1;
         next_rresp = mapped(s_axi_araddr) ? ccc_pkg::RESP_OKAY : ccc_pkg::RESP_SLVERR;
         case (s_axi_araddr)
            ccc_pkg::ADDR_CTRL: next_rdata = 32'(ctrl);
            ccc_pkg::ADDR_STEP: next_rdata = 32'(step);
            ccc_pkg::ADDR_OE_MASK: next_rdata = 32'(oe_mask);
            ccc_pkg::ADDR_STATUS: next_rdata = 32'(status);
            ccc_pkg::ADDR_IRQ_MASK: next_rdata = 32'(irq_mask);
            ccc_pkg::ADDR_STATE: begin
               next_rdata = 32'h0000_0000;
               next_rdata[ccc_pkg::STATE_LOCK_LSB +: 4] = lock;
               next_rdata[ccc_pkg::STATE_BOOT_BIT] = boot_mode;
               next_rdata[ccc_pkg::STATE_ADDR_LSB +: 7] = bus_target_addr;
            end
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

   // registers, lock tracking and step pulses
   always_comb begin
      next_ctrl = ctrl;
      next_step = step;
      next_oe_mask = oe_mask;
      next_irq_mask = irq_mask;
      next_status = status;
      next_lock = loop_locked;
      if (wr_fire) begin
         case (next_aw_addr)
            ccc_pkg::ADDR_CTRL: next_ctrl = next_w_data[ccc_pkg::CTRL_SEL_LSB +: 2];
            ccc_pkg::ADDR_STEP: next_step = next_w_data[STEP_W-1:0];
            ccc_pkg::ADDR_OE_MASK: next_oe_mask = next_w_data[N_OUT-1:0];
            ccc_pkg::ADDR_IRQ_MASK: next_irq_mask = next_w_data[4:0];
            default: next_ctrl = ctrl;
         endcase
      end
      // read clears, but a same-cycle event still sets
      if (rd_fire && s_axi_araddr == ccc_pkg::ADDR_STATUS)
         next_status = 5'h00;
      // RL5 status change events
      next_status[3:0] = next_status[3:0] | (lock ^ loop_locked);
      next_status[ccc_pkg::STATUS_STEP_BIT] = next_status[ccc_pkg::STATUS_STEP_BIT] |
         up_rise | dn_rise;
      // RL8 one step down per edge
      next_dn = dn_rise;
      // RL9 one step up per edge
      next_up = up_rise;
      // RL6 masked outputs follow the pin
      for (int i = 0; i < N_OUT; i++)
         next_clk_en[i] = ~(oe_mask[i] & output_enable_n);
   end

   // RL2 defaults on either reset
   always_ff @(posedge clk_sys) begin
      if (!soft_rst_n) begin
         ctrl <= ccc_pkg::CTRL_RST;
         step <= STEP_W'(ccc_pkg::STEP_RST);
         oe_mask <= N_OUT'(ccc_pkg::OE_MASK_RST);
         irq_mask <= ccc_pkg::IRQ_MASK_RST;
         status <= 5'h00;
         lock <= 4'(ccc_pkg::LOCK_RST);
         clk_out_en <= '0;
         step_up <= 1'b0;
         step_down <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         step <= next_step;
         oe_mask <= next_oe_mask;
         irq_mask <= next_irq_mask;
         status <= next_status;
         lock <= next_lock;
         clk_out_en <= next_clk_en;
         step_up <= next_up;
         step_down <= next_dn;
      end
   end

   // RL10 strap caught at release
   always_comb begin
      next_boot = boot_mode;
      next_addr = bus_target_addr;
      if (was_rst) begin
         next_boot = ~boot_loader_strap_n;
         // RL12 address pins sampled
         next_addr = {ADDR_BASE, bus_addr_sel_hi, bus_addr_sel_lo};
      end
   end

   // pins are sampled on the first edge after release, and on every edge while the pin reset is held
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         was_rst <= 1'b1;
         boot_mode <= 1'b0;
         bus_target_addr <= 7'h00;
      end else begin
         was_rst <= pin_reset;
         boot_mode <= next_boot;
         bus_target_addr <= next_addr;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_low_long;
      u_rst.count == 12'(ccc_pkg::RST_HOLD_CYC - 1) && !u_rst.level;
   endsequence

   a_rst_reaches_core: assert property ( // RL1
      s_low_long |=> device_in_reset)
      else $error("long reset pulse did not reset the core");
   a_clk_off_reset: assert property ( // RL2
      device_in_reset |=> clk_out_en == '0)
      else $error("clock outputs on during reset");
   a_por_pulls_pin: assert property ( // RL3
      por_active |-> !device_reset_n_oe_n && !device_reset_n_out)
      else $error("reset pin not pulled during por");
   a_irq_on_change: assert property ( // RL5
      soft_rst_n && !device_in_reset && $changed(loop_locked) && &irq_mask[3:0] && !rd_fire
      ##1 !device_in_reset |-> !irq_n)
      else $error("lock change gave no interrupt");
   a_oe_gates_mask: assert property ( // RL6
      !device_in_reset && oe_mask[0] && output_enable_n ##1 !device_in_reset |-> !clk_out_en[0])
      else $error("masked output not gated");
   a_lock_follows: assert property ( // RL7
      !device_in_reset ##1 !device_in_reset |-> loop_a_unlocked_n == $past(loop_locked[0]))
      else $error("loss of lock output wrong");
   a_step_once: assert property ( // RL14
      step_up |=> !step_up)
      else $error("step pulse longer than one cycle");
   a_step_from_pin: assert property ( // RL9
      !device_in_reset && $rose(freq_step_up) ##1 !device_in_reset [*3] |-> step_up)
      else $error("increment edge gave no step");
   a_stretch_slow: assert property ( // RL11
      !serial_fast |-> scl_oe_n)
      else $error("clock stretched at standard rate");
endmodule : ccc_ctrl

// File: verilog/ccc_pkg.sv
// constants shared by the clock chip control and status logic
package ccc_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STEP = 8'h04;
   localparam logic [7:0] ADDR_OE_MASK = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
   localparam logic [7:0] ADDR_STATE = 8'h14;
   // field positions
   localparam int CTRL_SEL_LSB = 0;
   localparam int STATE_LOCK_LSB = 0;
   localparam int STATE_BOOT_BIT = 4;
   localparam int STATE_ADDR_LSB = 8;
   localparam int STATUS_STEP_BIT = 4;
   // reset values
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [15:0] STEP_RST = 16'h0001;
   localparam logic [6:0] OE_MASK_RST = 7'h7f;
   localparam logic [4:0] IRQ_MASK_RST = 5'h00;
   localparam logic [4:0] LOCK_RST = 5'h0f;
   // reset pin hold time, strictly longer than this
   localparam int CLK_PERIOD_NS = 10;
   localparam int RST_HOLD_NS = 15000;
   localparam int RST_HOLD_CYC = RST_HOLD_NS / CLK_PERIOD_NS + 1;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ccc_pkg

// File: verilog/ccc_sync_edge.sv
// two-flop synchroniser with rising edge pulse
module ccc_sync_edge (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // pin and result
   input wire logic pin,
   output logic level,
   output logic rise
);
   logic meta;
   logic next_meta;
   logic next_level;
   logic prev;
   logic next_prev;

   always_comb begin
      next_meta = pin;
      next_level = meta;
      next_prev = level;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta <= 1'b0;
         level <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= next_meta;
         level <= next_level;
         prev <= next_prev;
      end
   end

   // one pulse per edge, taken from the second flop only
   assign rise = level & ~prev;
endmodule : ccc_sync_edge

// File: verilog/ccc_reset_filter.sv
// reset pin qualifier: long low pulses become a device reset
module ccc_reset_filter (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // pin level and qualified reset
   input wire logic pin_n,
   output logic pin_reset
);
   logic meta;
   logic level;
   logic [11:0] count;
   logic [11:0] next_count;
   logic next_pin_reset;

   always_comb begin
      next_count = count;
      next_pin_reset = 1'b0;
      if (!level) begin
         if (count < 12'(ccc_pkg::RST_HOLD_CYC))
            next_count = count + 12'h001;
         next_pin_reset = (count >= 12'(ccc_pkg::RST_HOLD_CYC - 1));
      end else begin
         next_count = 12'h000;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta <= 1'b1;
         level <= 1'b1;
         count <= 12'h000;
         pin_reset <= 1'b0;
      end else begin
         meta <= pin_n;
         level <= meta;
         count <= next_count;
         pin_reset <= next_pin_reset;
      end
   end
endmodule : ccc_reset_filter

// File: dv/ccc_host_model.sv
// host side model: shared reset line, strap and control pins
module ccc_host_model (
   // bench requests
   input wire logic hold_reset,
   input wire logic boot_req,
   input wire logic disable_req,
   input wire logic up_req,
   input wire logic down_req,
   // device reset pin
   input wire logic dev_out,
   input wire logic dev_oe_n,
   output logic reset_line_n,
   // pins toward the device
   output logic strap_n,
   output logic oe_pin_n,
   output logic up_pin,
   output logic down_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // open drain only
   // wired-and with the pull-up, the host never drives the line high
   assign reset_line_n = (dev_oe_n | dev_out) & ~hold_reset;
   assign strap_n = ~boot_req;
   assign oe_pin_n = disable_req;
   assign up_pin = up_req;
   assign down_pin = down_req;
endmodule : ccc_host_model

// File: dv/ccc_ctrl_bench.sv
// self-checking bench of the control and status pin logic
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] t=%0t got %0h exp %0h", $time, g, e); end end
module ccc_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'h0, rst_n = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, step_loop_sel;
   logic device_reset_n_in, device_reset_n_out, device_reset_n_oe_n, por_active = 1'h0;
   logic output_enable_n, freq_step_up, freq_step_down, boot_loader_strap_n;
   logic bus_addr_sel_hi = 1'h1, bus_addr_sel_lo = 1'h0;
   logic [3:0] loop_locked = 4'hf;
   logic serial_fast = 1'h0, serial_wait_req = 1'h0, scl_out, scl_oe_n, irq_n;
   logic loop_a_unlocked_n, loop_c_unlocked_n, loop_d_unlocked_n, reference_unlocked_n;
   logic step_up, step_down, boot_mode, device_in_reset;
   logic [6:0] clk_out_en, bus_target_addr;
   logic [15:0] step_size;
   logic hold_reset = 1'h0, boot_req = 1'h0, disable_req = 1'h0;
   logic up_req = 1'h0, down_req = 1'h0;
   int bad_count = 0, checked = 0;

   always #5 clk_sys = ~clk_sys;

   ccc_ctrl ccc_ctrl_inst (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .device_reset_n_in, .device_reset_n_out,
      .device_reset_n_oe_n, .por_active, .output_enable_n, .freq_step_up, .freq_step_down,
      .boot_loader_strap_n, .bus_addr_sel_hi, .bus_addr_sel_lo, .loop_locked, .serial_fast,
      .serial_wait_req, .scl_out, .scl_oe_n, .irq_n, .loop_a_unlocked_n, .loop_c_unlocked_n,
      .loop_d_unlocked_n, .reference_unlocked_n, .clk_out_en, .step_up, .step_down,
      .step_loop_sel, .step_size, .boot_mode, .bus_target_addr, .device_in_reset);

   ccc_host_model ccc_host_model_inst (.hold_reset, .boot_req, .disable_req, .up_req,
      .down_req, .dev_out(device_reset_n_out), .dev_oe_n(device_reset_n_oe_n),
      .reset_line_n(device_reset_n_in), .strap_n(boot_loader_strap_n),
      .oe_pin_n(output_enable_n), .up_pin(freq_step_up), .down_pin(freq_step_down));

   task automatic results;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1 && n < 100);
      s_axi_bready <= 1'h0;
      `CHK(s_axi_bvalid, 1'h1);
      `CHK(s_axi_bresp, er);
      // one edge with ready low before a following call raises it again
      @(posedge clk_sys);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1 && n < 100);
      s_axi_rready <= 1'h0;
      `CHK(s_axi_rvalid, 1'h1);
      `CHK(s_axi_rdata, ed);
      `CHK(s_axi_rresp, er);
      @(posedge clk_sys);
   endtask : rd

   // holds the pin high for six cycles: a level must not give repeated steps
   task automatic pulse_pin(input logic up, output int nu, output int nd);
      nu = 0;
      nd = 0;
      if (up) up_req <= 1'h1;
      else down_req <= 1'h1;
      for (int k = 0; k < 12; k++) begin
         @(posedge clk_sys);
         nu += (step_up === 1'h1);
         nd += (step_down === 1'h1);
         if (k == 5) begin
            up_req <= 1'h0;
            down_req <= 1'h0;
         end
      end
   endtask : pulse_pin

   task automatic t_defaults;
      rd(ccc_pkg::ADDR_CTRL, 32'h0, ccc_pkg::RESP_OKAY);
      rd(ccc_pkg::ADDR_STEP, 32'h1, ccc_pkg::RESP_OKAY);
      rd(ccc_pkg::ADDR_OE_MASK, 32'h7f, ccc_pkg::RESP_OKAY);
      rd(ccc_pkg::ADDR_IRQ_MASK, 32'h0, ccc_pkg::RESP_OKAY);
      rd(ccc_pkg::ADDR_STATE, {17'h0, 5'h1a, 2'h2, 8'h0f}, ccc_pkg::RESP_OKAY);
      rd(8'h40, 32'h0, ccc_pkg::RESP_SLVERR);
      wr(8'h44, 32'h5, ccc_pkg::RESP_SLVERR);
      `CHK(clk_out_en, 7'h7f);
      `CHK(bus_target_addr, 7'h6a);
      `CHK(boot_mode, 1'h0);
      `CHK(irq_n, 1'h1);
      $display("defaults test done");
   endtask : t_defaults

   task automatic t_oe_mask;
      wr(ccc_pkg::ADDR_OE_MASK, 32'h0f, ccc_pkg::RESP_OKAY);
      disable_req <= 1'h1;
      repeat (3) @(posedge clk_sys);
      `CHK(clk_out_en, 7'h70);
      disable_req <= 1'h0;
      repeat (3) @(posedge clk_sys);
      `CHK(clk_out_en, 7'h7f);
      $display("output enable test done");
   endtask : t_oe_mask

   task automatic t_lock;
      wr(ccc_pkg::ADDR_IRQ_MASK, 32'h0f, ccc_pkg::RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         loop_locked <= ~(4'h1 << i);
         repeat (3) @(posedge clk_sys);
         `CHK({reference_unlocked_n, loop_d_unlocked_n, loop_c_unlocked_n,
            loop_a_unlocked_n}, ~(4'h1 << i));
         `CHK(irq_n, 1'h0);
         rd(ccc_pkg::ADDR_STATUS, 32'h1 << i, ccc_pkg::RESP_OKAY);
         @(posedge clk_sys);
         `CHK(irq_n, 1'h1);
         loop_locked <= 4'hf;
         repeat (3) @(posedge clk_sys);
         `CHK({reference_unlocked_n, loop_d_unlocked_n, loop_c_unlocked_n,
            loop_a_unlocked_n}, 4'hf);
         rd(ccc_pkg::ADDR_STATUS, 32'h1 << i, ccc_pkg::RESP_OKAY);
      end
      $display("lock test done");
   endtask : t_lock

   task automatic t_step;
      int nu, nd;
      wr(ccc_pkg::ADDR_CTRL, 32'h2, ccc_pkg::RESP_OKAY);
      wr(ccc_pkg::ADDR_STEP, 32'h0123, ccc_pkg::RESP_OKAY);
      pulse_pin(1'h1, nu, nd);
      `CHK(nu, 1);
      `CHK(nd, 0);
      pulse_pin(1'h0, nu, nd);
      `CHK(nd, 1);
      `CHK(nu, 0);
      `CHK(step_loop_sel, 2'h2);
      `CHK(step_size, 16'h0123);
      rd(ccc_pkg::ADDR_STATUS, 32'h10, ccc_pkg::RESP_OKAY);
      $display("step test done");
   endtask : t_step

   task automatic t_serial;
      serial_fast <= 1'h1;
      serial_wait_req <= 1'h1;
      repeat (2) @(posedge clk_sys);
      `CHK(scl_oe_n, 1'h0);
      `CHK(scl_out, 1'h0);
      serial_fast <= 1'h0;
      repeat (2) @(posedge clk_sys);
      `CHK(scl_oe_n, 1'h1);
      serial_wait_req <= 1'h0;
      $display("serial clock test done");
   endtask : t_serial

   task automatic t_por;
      por_active <= 1'h1;
      repeat (2) @(posedge clk_sys);
      `CHK(device_reset_n_oe_n, 1'h0);
      `CHK(device_reset_n_in, 1'h0);
      `CHK(device_reset_n_out, 1'h0);
      repeat (20) @(posedge clk_sys);
      por_active <= 1'h0;
      repeat (4) @(posedge clk_sys);
      `CHK(device_reset_n_in, 1'h1);
      `CHK(device_in_reset, 1'h0);
      $display("power-on pin test done");
   endtask : t_por

   // a long pin reset with the strap low: defaults back, bootloader chosen
   task automatic t_pin_reset;
      hold_reset <= 1'h1;
      boot_req <= 1'h1;
      repeat (1400) @(posedge clk_sys);
      `CHK(device_in_reset, 1'h0);
      repeat (200) @(posedge clk_sys);
      `CHK(device_in_reset, 1'h1);
      `CHK(clk_out_en, 7'h00);
      hold_reset <= 1'h0;
      repeat (10) @(posedge clk_sys);
      boot_req <= 1'h0;
      `CHK(device_in_reset, 1'h0);
      `CHK(boot_mode, 1'h1);
      rd(ccc_pkg::ADDR_STEP, 32'h1, ccc_pkg::RESP_OKAY);
      rd(ccc_pkg::ADDR_OE_MASK, 32'h7f, ccc_pkg::RESP_OKAY);
      rd(ccc_pkg::ADDR_CTRL, 32'h0, ccc_pkg::RESP_OKAY);
      $display("pin reset test done");
   endtask : t_pin_reset

   initial begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'h1;
      @(posedge clk_sys);
      t_defaults();
      t_oe_mask();
      t_lock();
      t_step();
      t_serial();
      t_por();
      t_pin_reset();
      results();
   end

   // the tests need about 1800 cycles
   initial begin
      #100000;
      bad_count++;
      results();
   end
endmodule : ccc_ctrl_bench
